/* File: logic/modem_regs_pkg.sv */
// shared constants and carrier types for the receive status register group
// assumes a single 200 MHz clock domain and the serial register port pins
package modem_regs_pkg;

	// ==========================================================
	// register addresses (7-bit serial port address)
	localparam logic [6:0] ADDR_HOST_PTR     = 7'h0D;
	localparam logic [6:0] ADDR_RX_BASE      = 7'h0F;
	localparam logic [6:0] ADDR_LAST_START   = 7'h10;
	localparam logic [6:0] ADDR_IRQ_MASK     = 7'h11;
	localparam logic [6:0] ADDR_IRQ_FLAGS    = 7'h12;
	localparam logic [6:0] ADDR_RX_LEN       = 7'h13;
	localparam logic [6:0] ADDR_HDR_HIGH     = 7'h14;
	localparam logic [6:0] ADDR_HDR_LOW      = 7'h15;
	localparam logic [6:0] ADDR_PKT_HIGH     = 7'h16;
	localparam logic [6:0] ADDR_PKT_LOW      = 7'h17;
	localparam logic [6:0] ADDR_MODEM_STATE  = 7'h18;
	localparam logic [6:0] ADDR_STEP         = 7'h01;

	// ==========================================================
	// reset values and counter constants
	localparam logic [7:0] RST_HOST_PTR      = 8'h00;
	localparam logic [7:0] RST_RX_BASE       = 8'h00;
	localparam logic [7:0] RST_IRQ_MASK      = 8'h00;
	localparam logic [7:0] RST_IRQ_FLAGS     = 8'h00;
	localparam logic [7:0] RST_UNMAPPED      = 8'h00;
	localparam logic [15:0] COUNT_MAX        = 16'hFFFF;
	localparam logic [15:0] COUNT_ONE        = 16'h0001;
	localparam logic [15:0] COUNT_ZERO       = 16'h0000;

	// ==========================================================
	// field positions
	localparam int FLAG_RX_TIMEOUT   = 7;
	localparam int FLAG_RX_DONE      = 6;
	localparam int FLAG_CHECK_FAIL   = 5;
	localparam int FLAG_HEADER_OK    = 4;
	localparam int FLAG_TX_DONE      = 3;
	localparam int FLAG_SCAN_DONE    = 2;
	localparam int FLAG_HOP_CHANNEL  = 1;
	localparam int FLAG_ACT_FOUND    = 0;
	localparam int CODE_RATE_LSB     = 5;
	localparam int MODEM_CLEAR_BIT   = 4;
	localparam int SPI_WRITE_BIT     = 7;
	localparam logic [2:0] SPI_LAST_BIT = 3'h7;
	localparam logic [2:0] SPI_FIRST_BIT = 3'h0;

	// ==========================================================
	// carrier types
	typedef struct packed {
		logic receive_timeout_flag;
		logic reception_complete_flag;
		logic payload_check_fail_flag;
		logic header_ok_flag;
		logic transmit_complete_flag;
		logic activity_scan_done_flag;
		logic hop_channel_flag;
		logic activity_found_flag;
	} irq_events_t;

	typedef struct packed {
		logic [7:0] last_packet_start;
		logic [7:0] rx_payload_byte_count;
		logic [2:0] received_code_rate;
		logic [4:0] modem_state_bits;
	} rx_report_t;

	typedef struct packed {
		logic sck;
		logic nss_b;
		logic mosi;
	} spi_pins_t;

	typedef struct packed {
		logic sleep;
		logic rx_mode;
	} op_mode_t;

	localparam rx_report_t RST_REPORT = '{8'h00, 8'h00, 3'h0, 5'h10};
	localparam spi_pins_t  RST_PINS   = '{1'b0, 1'b1, 1'b0};

	typedef enum logic [1:0] {
		SPI_IDLE = 2'b00,
		SPI_ADDR = 2'b01,
		SPI_DATA = 2'b11
	} spi_phase_t;

endpackage : modem_regs_pkg

/* File: logic/pin_sync.sv */
// two-flop synchroniser for the serial port pins
// assumes pins are asynchronous to clk_in
module pin_sync
	import modem_regs_pkg::*;
(
	input  wire logic      clk_in,
	input  wire logic      rst_b_in,
	input  wire spi_pins_t pins_in,
	output spi_pins_t      pins_out
);
	import modem_regs_pkg::*;

	spi_pins_t stage1_q;
	spi_pins_t stage2_q;

	// ==========================================================
	// first stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			stage1_q <= RST_PINS;
			stage2_q <= RST_PINS;
		end else begin
			stage1_q <= pins_in;
			stage2_q <= stage1_q;
		end
	end

	assign pins_out = stage2_q;

endmodule : pin_sync

/* File: logic/sat_counter.sv */
// 16-bit saturating event counter with synchronous clear
// assumes inc_in is a one-cycle pulse on clk_in
module sat_counter
	import modem_regs_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rst_b_in,
	input  wire logic        clear_in,
	input  wire logic        inc_in,
	output logic [15:0]      count_out
);
	import modem_regs_pkg::*;

	logic [15:0] count_q;

	// ==========================================================
	// clear beats increment; stop at the top
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			count_q <= COUNT_ZERO;
		end else if (clear_in) begin
			count_q <= COUNT_ZERO;
		end else if (inc_in && (count_q != COUNT_MAX)) begin
			count_q <= count_q + COUNT_ONE;
		end
	end

	assign count_out = count_q;

endmodule : sat_counter

/* File: logic/modem_irq_rx_status_regs.sv */
// receive status register group behind the serial register port
// assumes modem events are one-cycle pulses and reports are levels on clk_in
//
// What this block does
// - A read/write receive base pointer, reset to zero, tells the demodulator where to store payload.
// - A read-only register shows where the last received packet starts in the buffer.
// - Eight read/write mask bits, reset to zero, each hide the interrupt indication of one flag.
// - Flag bits are timeout, done, check fail, header ok, transmit done, scan done, hop, activity from bit 7 down.
// - A flag clears only when the host writes a one to it, zeros change nothing, and all reset to zero.
// - A read-only register shows the payload byte count of the last packet.
// - A 16-bit valid-header count is readable as a high and a low byte.
// - A 16-bit valid-packet count is readable as a high and a low byte.
// - Both counts go to zero while the modem is in Sleep.
// - Status bits 7 to 5 show the coding rate of the last header received.
// - Status bit 4 shows modem clear and reads one after reset.
// - Status bits 3 to 0 show header valid, receive on-going, synchronised and detected, zero after reset.
// - A host-writable pointer selects the buffer location that payload access through the port uses.
module modem_irq_rx_status_regs
	import modem_regs_pkg::*;
(
	input  wire logic                     clk_in,
	input  wire logic                     rst_b_in,
	input  wire modem_regs_pkg::spi_pins_t spi_in,
	output logic                          miso_out,
	output logic                          miso_oe_out,
	input  wire modem_regs_pkg::irq_events_t events_in,
	input  wire modem_regs_pkg::rx_report_t  report_in,
	input  wire modem_regs_pkg::op_mode_t    mode_in,
	output logic [7:0]                    rx_buffer_base_out,
	output logic [7:0]                    host_buffer_pointer_out,
	output modem_regs_pkg::irq_events_t   irq_pending_out
);
	import modem_regs_pkg::*;

	spi_pins_t   pins_s;
	logic        sck_prev_q;
	logic        sck_rise;
	logic        sck_fall;
	spi_phase_t  phase_q;
	logic [2:0]  bit_cnt_q;
	logic [7:0]  shift_in_q;
	logic [7:0]  shift_next;
	logic [7:0]  shift_out_q;
	logic        miso_q;
	logic        write_q;
	logic [6:0]  addr_q;
	logic        byte_done;
	logic [6:0]  rd_addr;
	logic [7:0]  rd_data;
	logic        wr_stb;
	logic [7:0]  rx_base_q;
	logic [7:0]  host_ptr_q;
	logic [7:0]  irq_mask_q;
	irq_events_t irq_flags_q;
	irq_events_t flag_clear;
	rx_report_t  report_q;
	logic        rx_mode_prev_q;
	logic        count_clear;
	logic        packet_ok;
	logic [15:0] header_count;
	logic [15:0] packet_count;

	// ==========================================================
	// pin synchronisation and clock edges
	pin_sync u_pin_sync (
		.clk_in   (clk_in),
		.rst_b_in (rst_b_in),
		.pins_in  (spi_in),
		.pins_out (pins_s)
	);

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			sck_prev_q <= 1'b0;
		end else begin
			sck_prev_q <= pins_s.sck;
		end
	end

	assign sck_rise   = pins_s.sck & ~sck_prev_q & ~pins_s.nss_b;
	assign sck_fall   = ~pins_s.sck & sck_prev_q & ~pins_s.nss_b;
	assign shift_next = {shift_in_q[6:0], pins_s.mosi};
	assign byte_done  = sck_rise && (bit_cnt_q == SPI_LAST_BIT);

	// ==========================================================
	// frame phase: address byte then data bytes
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			phase_q <= SPI_IDLE;
		end else if (pins_s.nss_b) begin
			phase_q <= SPI_IDLE;
		end else begin
			case (phase_q)
				SPI_IDLE: begin
					phase_q <= SPI_ADDR;
				end
				SPI_ADDR: begin
					if (byte_done) begin
						phase_q <= SPI_DATA;
					end
				end
				SPI_DATA: begin
					phase_q <= SPI_DATA;
				end
				default: begin
					phase_q <= SPI_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// receive shifter and bit count
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			bit_cnt_q  <= SPI_FIRST_BIT;
			shift_in_q <= 8'h00;
		end else if (pins_s.nss_b) begin
			bit_cnt_q  <= SPI_FIRST_BIT;
			shift_in_q <= 8'h00;
		end else if (sck_rise) begin
			bit_cnt_q  <= bit_cnt_q + 3'h1;
			shift_in_q <= shift_next;
		end
	end

	// ==========================================================
	// address capture and burst increment
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			write_q <= 1'b0;
			addr_q  <= 7'h00;
		end else if (byte_done && (phase_q == SPI_ADDR)) begin
			write_q <= shift_next[SPI_WRITE_BIT];
			addr_q  <= shift_next[6:0];
		end else if (byte_done && (phase_q == SPI_DATA)) begin
			addr_q  <= addr_q + ADDR_STEP;
		end
	end

	assign wr_stb  = byte_done && (phase_q == SPI_DATA) && write_q;
	assign rd_addr = (phase_q == SPI_ADDR) ? shift_next[6:0] : addr_q + ADDR_STEP;

	// ==========================================================
	// read multiplexer; unmapped addresses read zero
	always_comb begin
		rd_data = RST_UNMAPPED;
		case (rd_addr)
			ADDR_HOST_PTR:    rd_data = host_ptr_q;
			ADDR_RX_BASE:     rd_data = rx_base_q;
			ADDR_LAST_START:  rd_data = report_q.last_packet_start;
			ADDR_IRQ_MASK:    rd_data = irq_mask_q;
			ADDR_IRQ_FLAGS:   rd_data = irq_flags_q;
			ADDR_RX_LEN:      rd_data = report_q.rx_payload_byte_count;
			ADDR_HDR_HIGH:    rd_data = header_count[15:8];
			ADDR_HDR_LOW:     rd_data = header_count[7:0];
			ADDR_PKT_HIGH:    rd_data = packet_count[15:8];
			ADDR_PKT_LOW:     rd_data = packet_count[7:0];
			ADDR_MODEM_STATE: rd_data = {report_q.received_code_rate, report_q.modem_state_bits};
			default:          rd_data = RST_UNMAPPED;
		endcase
	end

	// ==========================================================
	// transmit shifter: load at byte end, shift on falling edge
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			shift_out_q <= 8'h00;
			miso_q      <= 1'b0;
		end else if (pins_s.nss_b) begin
			shift_out_q <= 8'h00;
			miso_q      <= 1'b0;
		end else if (byte_done) begin
			shift_out_q <= rd_data;
		end else if (sck_fall) begin
			miso_q      <= shift_out_q[7];
			shift_out_q <= {shift_out_q[6:0], 1'b0};
		end
	end

	assign miso_out    = miso_q;
	assign miso_oe_out = ~pins_s.nss_b;

	// ==========================================================
	// host-written control registers
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rx_base_q <= RST_RX_BASE;
		end else if (wr_stb && (addr_q == ADDR_RX_BASE)) begin
			rx_base_q <= shift_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			host_ptr_q <= RST_HOST_PTR;
		end else if (wr_stb && (addr_q == ADDR_HOST_PTR)) begin
			host_ptr_q <= shift_next;
		end
	end

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			irq_mask_q <= RST_IRQ_MASK;
		end else if (wr_stb && (addr_q == ADDR_IRQ_MASK)) begin
			irq_mask_q <= shift_next;
		end
	end

	assign rx_buffer_base_out      = rx_base_q;
	assign host_buffer_pointer_out = host_ptr_q;

	// ==========================================================
	// sticky flags, write one to clear, new event wins
	assign flag_clear = (wr_stb && (addr_q == ADDR_IRQ_FLAGS)) ? irq_events_t'(shift_next) : irq_events_t'(8'h00);

	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			irq_flags_q <= irq_events_t'(RST_IRQ_FLAGS);
		end else begin
			irq_flags_q <= (irq_flags_q & ~flag_clear) | events_in;
		end
	end

	assign irq_pending_out = irq_flags_q & ~irq_events_t'(irq_mask_q);

	// ==========================================================
	// modem report capture
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			report_q <= RST_REPORT;
		end else begin
			report_q <= report_in;
		end
	end

	// ==========================================================
	// header and packet counters
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			rx_mode_prev_q <= 1'b0;
		end else begin
			rx_mode_prev_q <= mode_in.rx_mode;
		end
	end

	assign count_clear = mode_in.sleep | (mode_in.rx_mode & ~rx_mode_prev_q);
	assign packet_ok   = events_in.reception_complete_flag & ~events_in.payload_check_fail_flag;

	sat_counter u_header_count (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.clear_in  (count_clear),
		.inc_in    (events_in.header_ok_flag),
		.count_out (header_count)
	);

	sat_counter u_packet_count (
		.clk_in    (clk_in),
		.rst_b_in  (rst_b_in),
		.clear_in  (count_clear),
		.inc_in    (packet_ok),
		.count_out (packet_count)
	);

endmodule : modem_irq_rx_status_regs

/* File: bench/modem_regs_monitor.sv */
// port checker for the receive status register group
// assumes nss and sck held >= 4 clk per phase
module modem_regs_monitor
	import modem_regs_pkg::*;
(
	input wire logic        clk_in,
	input wire logic        rst_b_in,
	input wire spi_pins_t   spi_in,
	input wire logic        miso_out,
	input wire logic        miso_oe_out,
	input wire irq_events_t events_in,
	input wire logic [7:0]  rx_buffer_base_out,
	input wire logic [7:0]  host_buffer_pointer_out,
	input wire irq_events_t irq_pending_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	// ====
	// port quiet, no write in flight
	sequence idle_s;
		spi_in.nss_b [*5];
	endsequence
	sequence busy_s;
		(!spi_in.nss_b) [*3];
	endsequence
	base_reset_a: assert property ($rose(rst_b_in) |-> rx_buffer_base_out == 8'h00
		&& host_buffer_pointer_out == 8'h00) else $error("base or pointer not zero after reset");
	pend_reset_a: assert property ($rose(rst_b_in) |-> irq_pending_out == 8'h00)
		else $error("pending not zero after reset");
	flags_hold_a: assert property (idle_s |=> (irq_pending_out & $past(irq_pending_out))
		== $past(irq_pending_out)) else $error("flag fell without host write");
	flag_cause_a: assert property (idle_s |=> (irq_pending_out & ~$past(irq_pending_out)
		& ~$past(events_in)) == 8'h00) else $error("flag rose without its event");
	base_hold_a: assert property (idle_s |=> $stable(rx_buffer_base_out))
		else $error("base changed without write");
	ptr_hold_a: assert property (idle_s |=> $stable(host_buffer_pointer_out))
		else $error("pointer changed without write");
	oe_on_a: assert property (busy_s |-> miso_oe_out) else $error("miso not driven in frame");
	oe_off_a: assert property (spi_in.nss_b [*3] |-> !miso_oe_out) else $error("miso driven idle");
	miso_idle_a: assert property (idle_s |-> !miso_out) else $error("miso not low idle");
	miso_hold_a: assert property ((spi_in.sck && !spi_in.nss_b) [*6] |-> $stable(miso_out))
		else $error("miso moved while sck high");
endmodule : modem_regs_monitor

bind modem_irq_rx_status_regs modem_regs_monitor u_modem_regs_monitor (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.spi_in(spi_in), .miso_out(miso_out), .miso_oe_out(miso_oe_out), .events_in(events_in),
	.rx_buffer_base_out(rx_buffer_base_out), .host_buffer_pointer_out(host_buffer_pointer_out),
	.irq_pending_out(irq_pending_out));

/* File: bench/spi_host_model.sv */
// host side of the serial register port, mode 0, msb first
// assumes clk_in running; pins change at falling clk edges
module spi_host_model
	import modem_regs_pkg::*;
#(
	parameter int HALF = 6
)
(
	input  wire logic clk_in,
	input  wire logic miso_in,
	output spi_pins_t pins_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial pins_out = RST_PINS;
	// ====
	// one frame: address byte then n data bytes
	task automatic xfer(input logic wnr, input logic [6:0] addr, input int n,
		input logic [7:0] wd [16], output logic [7:0] rd [16]);
		logic [7:0] tx;
		logic [7:0] rx;
		@(negedge clk_in);
		pins_out.nss_b = 1'b0;
		for (int b = 0; b <= n; b++) begin
			tx = (b == 0) ? {wnr, addr} : wd[b - 1];
			for (int i = 7; i >= 0; i--) begin
				pins_out.mosi = tx[i];
				repeat (HALF) @(negedge clk_in);
				pins_out.sck = 1'b1;
				rx[i] = miso_in;
				repeat (HALF) @(negedge clk_in);
				pins_out.sck = 1'b0;
			end
			if (b > 0) rd[b - 1] = rx;
		end
		repeat (HALF) @(negedge clk_in);
		pins_out.nss_b = 1'b1;
		pins_out.mosi = ~pins_out.mosi;
		repeat (4) @(negedge clk_in);
	endtask : xfer
endmodule : spi_host_model

/* File: bench/tb.sv */
// self-checking bench for the receive status register group
// assumes the host model for port access; counts saturate after ~65k events
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin failures++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import modem_regs_pkg::*;
	logic        clk_in = 1'b0;
	logic        rst_b_in = 1'b0;
	spi_pins_t   spi;
	logic        miso, miso_oe;
	irq_events_t ev = '0;
	irq_events_t pend;
	rx_report_t  rep = RST_REPORT;
	op_mode_t    mode = '0;
	logic [7:0]  base_o, ptr_o;
	logic [7:0]  wd [16];
	logic [7:0]  rd [16];
	logic [31:0] seed = 32'hC07149EF;
	logic [23:0] m_rep = RST_REPORT;
	int          m_base = 0, m_ptr = 0, m_mask = 0, m_flags = 0, m_hdr = 0, m_pkt = 0;
	logic        prev_rx = 1'b0;
	int          failures = 0, n_compared = 0, cycles = 0;

	modem_irq_rx_status_regs u_modem_irq_rx_status_regs (.clk_in(clk_in), .rst_b_in(rst_b_in), .spi_in(spi),
		.miso_out(miso), .miso_oe_out(miso_oe), .events_in(ev), .report_in(rep), .mode_in(mode),
		.rx_buffer_base_out(base_o), .host_buffer_pointer_out(ptr_o), .irq_pending_out(pend));
	spi_host_model u_spi_host_model (.clk_in(clk_in), .miso_in(miso), .pins_out(spi));

	always #2.5 clk_in = ~clk_in;
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 90000) begin
			failures++;
			give_verdict();
		end
	end
	// ====
	// helpers
	function automatic logic [7:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed[7:0];
	endfunction : rnd
	function automatic logic [7:0] exp_rd(input int a);
		case (a & 'h7F)
			'h0D: return 8'(m_ptr);
			'h0F: return 8'(m_base);
			'h10: return m_rep[23:16];
			'h11: return 8'(m_mask);
			'h12: return 8'(m_flags);
			'h13: return m_rep[15:8];
			'h14: return 8'(m_hdr >> 8);
			'h15: return 8'(m_hdr);
			'h16: return 8'(m_pkt >> 8);
			'h17: return 8'(m_pkt);
			'h18: return m_rep[7:0];
			default: return 8'h00;
		endcase
	endfunction : exp_rd
	task automatic rd_chk(input logic [6:0] a, input int n);
		u_spi_host_model.xfer(1'b0, a, n, wd, rd);
		for (int k = 0; k < n; k++) `CHK("register", exp_rd(a + k), rd[k])
	endtask : rd_chk
	task automatic wr(input logic [6:0] a, input int n);
		u_spi_host_model.xfer(1'b1, a, n, wd, rd);
	endtask : wr
	task automatic tick(input logic [7:0] e, input logic sl, input logic rx);
		@(negedge clk_in);
		`CHK("pending", 8'(m_flags & ~m_mask), pend)
		ev = e;
		mode = '{sl, rx};
		if (sl || (rx && !prev_rx)) begin
			m_hdr = 0;
			m_pkt = 0;
		end else begin
			if (e[4] && m_hdr < 65535) m_hdr++;
			if (e[6] && !e[5] && m_pkt < 65535) m_pkt++;
		end
		m_flags |= e;
		prev_rx = rx;
	endtask : tick
	task automatic give_verdict();
		$display("compared %0d failures %0d", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : give_verdict
	// ====
	// main sequence
	initial begin
		repeat (8) @(negedge clk_in);
		rst_b_in = 1'b1;
		repeat (3) @(negedge clk_in);
		rd_chk(7'h0D, 12);
		// writes across unmapped, read-only and flag places
		for (int k = 0; k < 5; k++) wd[k] = rnd();
		wd[5] = 8'h00;
		wr(7'h0D, 6);
		m_ptr = wd[0];
		m_base = wd[2];
		m_mask = wd[4];
		`CHK("base out", 8'(m_base), base_o)
		`CHK("pointer out", 8'(m_ptr), ptr_o)
		rd_chk(7'h0D, 6);
		tick(8'h00, 1'b0, 1'b1);
		for (int k = 0; k < 200; k++) tick(rnd(), 1'b0, 1'b1);
		tick(8'h00, 1'b0, 1'b1);
		rd_chk(7'h12, 7);
		rd_chk(7'h12, 1);
		wd[0] = rnd();
		wr(7'h12, 1);
		m_flags &= ~int'(wd[0]);
		rd_chk(7'h12, 1);
		wd[0] = 8'hFF;
		wr(7'h12, 1);
		m_flags = 0;
		tick(8'h00, 1'b0, 1'b1);
		rep = {rnd(), rnd(), rnd()};
		m_rep = rep;
		tick(8'h00, 1'b0, 1'b1);
		rd_chk(7'h10, 9);
		tick(8'h50, 1'b0, 1'b1);
		tick(8'h00, 1'b1, 1'b1);
		tick(8'h00, 1'b0, 1'b1);
		rd_chk(7'h14, 4);
		tick(8'h50, 1'b0, 1'b1);
		tick(8'h00, 1'b0, 1'b0);
		tick(8'h50, 1'b0, 1'b1);
		tick(8'h50, 1'b0, 1'b1);
		tick(8'h00, 1'b0, 1'b1);
		rd_chk(7'h14, 4);
		repeat (65540) tick(8'h50, 1'b0, 1'b1);
		tick(8'h00, 1'b0, 1'b1);
		rd_chk(7'h14, 4);
		give_verdict();
	end
endmodule : tb
